// *** hw/lrd_cfg.svh ***
// Constants of the ladder reference control block
`ifndef LRD_CFG_SVH
`define LRD_CFG_SVH

`define LRD_LEVEL_W      5
`define LRD_LEVEL_COUNT  32
`define LRD_LEVEL_RST    5'h00
`define LRD_UPSEL_SUPPLY 2'h0
`define LRD_UPSEL_EXT    2'h1
`define LRD_UPSEL_FIXED  2'h2
`define LRD_UPSEL_RSVD   2'h3
`define LRD_LOSEL_GROUND 1'h0
`define LRD_LOSEL_EXT    1'h1
`define LRD_ENABLE_RST   1'h0
`define LRD_OE_RST       2'h0
`define LRD_UPSEL_RST    2'h0
`define LRD_LOSEL_RST    1'h0

`endif

// *** hw/lrd_ctrl.sv ***
// Control logic of the 5-bit resistor-ladder reference
`timescale 1ns/1ps
`include "lrd_cfg.svh"
module lrd_ctrl (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              ctrl_write,
    input  wire lrd_pkg::lrd_ctrl_t ctrl_in,
    input  wire logic              sleep_wake,
    input  wire logic [1:0]        pin_digital_in,
    input  wire logic              ladder_to_comparator,
    input  wire logic              ladder_to_adc,
    output lrd_pkg::lrd_ctrl_t     ctrl_state,
    output lrd_pkg::lrd_ladder_t   ladder,
    output lrd_pkg::lrd_pin_t      pin_ctrl,
    output logic [1:0]             pin_read,
    output logic                   comparator_ref_sel,
    output logic                   adc_channel_sel,
    output logic                   source_reserved
);
    import lrd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and decode helpers

    // Software control word, the only state that software writes
    lrd_ctrl_t   ctrl;

    // Two-stage synchroniser of the raw pin levels
    logic [1:0]  pin_sync1;
    logic [1:0]  pin_sync2;

    // Upper source decode; reserved code gives no source
    function automatic lrd_upper_t decode_upper(input logic [1:0] sel);
        case (sel)
            `LRD_UPSEL_SUPPLY: decode_upper = LRD_UP_SUPPLY;
            `LRD_UPSEL_EXT:    decode_upper = LRD_UP_EXT;
            `LRD_UPSEL_FIXED:  decode_upper = LRD_UP_FIXED_REF;
            default:           decode_upper = LRD_UP_NONE;
        endcase
    endfunction

    // Lower source decode; external pin or ground, never both
    function automatic logic lower_is_ext(input logic sel);
        lower_is_ext = sel == `LRD_LOSEL_EXT;
    endfunction

    // Level code to one-hot ladder tap
    function automatic logic [31:0] tap_of(input logic [4:0] code);
        tap_of = 32'h00000001 << code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control register; wake has no effect on it

    // Loaded whole on a write strobe, cleared on reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl.enable                 <= `LRD_ENABLE_RST;
            ctrl.pin_output_enable      <= `LRD_OE_RST;
            ctrl.positive_source_select <= `LRD_UPSEL_RST;
            ctrl.negative_source_select <= `LRD_LOSEL_RST;
            ctrl.level_select_field     <= `LRD_LEVEL_RST;
        end
        else if (ctrl_write)
        begin
            // Sleep and wake never reach this register
            ctrl <= ctrl_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ladder switch controls

    // Power, tap and source switches toward the analog ladder
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            // Everything open while in reset
            ladder.ladder_on       <= 1'h0;
            ladder.tap_select      <= 32'h00000000;
            ladder.upper_supply    <= 1'h0;
            ladder.upper_ext       <= 1'h0;
            ladder.upper_fixed_ref <= 1'h0;
            ladder.lower_ext       <= 1'h0;
            ladder.lower_ground    <= 1'h0;
        end
        else
        begin
            // Converter and tap live only while enabled
            ladder.ladder_on <= ctrl.enable;
            ladder.tap_select <= ctrl.enable ? tap_of(ctrl.level_select_field)
                                             : 32'h00000000;
            // Upper end: exactly one source, none on the reserved code
            ladder.upper_supply <= decode_upper(ctrl.positive_source_select)
                                   == LRD_UP_SUPPLY;
            ladder.upper_ext <= decode_upper(ctrl.positive_source_select)
                                == LRD_UP_EXT;
            ladder.upper_fixed_ref <= decode_upper(ctrl.positive_source_select)
                                      == LRD_UP_FIXED_REF;
            // Lower end: external pin or ground
            ladder.lower_ext <= lower_is_ext(ctrl.negative_source_select);
            ladder.lower_ground <= !lower_is_ext(ctrl.negative_source_select);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reserved upper select flag

    // Flags the code that leaves the ladder top unconnected
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            source_reserved <= 1'h0;
        end
        else
        begin
            source_reserved <= decode_upper(ctrl.positive_source_select)
                               == LRD_UP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin overrides, independent of the converter enable

    // Pins stay analog even while the converter is off
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_ctrl <= '0;
        end
        else
        begin
            // Analog switch from the ladder to the pin
            pin_ctrl.analog_connect     <= ctrl.pin_output_enable;
            // Digital functions released on analog pins
            pin_ctrl.digital_driver_off <= ctrl.pin_output_enable;
            pin_ctrl.pullup_off         <= ctrl.pin_output_enable;
            pin_ctrl.input_detect_off   <= ctrl.pin_output_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin read path: synchronise, then mask analog pins

    // Two flops against metastability on the raw pin levels
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_sync1 <= 2'h0;
            pin_sync2 <= 2'h0;
        end
        else
        begin
            pin_sync1 <= pin_digital_in;
            pin_sync2 <= pin_sync1;
        end
    end

    // Analog pins read zero; detector is off there
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_read <= 2'h0;
        end
        else
        begin
            pin_read <= pin_sync2 & ~ctrl.pin_output_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal reference routing

    // Ladder output onto the comparator positive input
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            comparator_ref_sel <= 1'h0;
        end
        else
        begin
            comparator_ref_sel <= ladder_to_comparator;
        end
    end

    // Ladder output onto a converter input channel
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            adc_channel_sel <= 1'h0;
        end
        else
        begin
            adc_channel_sel <= ladder_to_adc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control word readback

    // Registered copy so the port comes from a flop
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_state <= '0;
        end
        else
        begin
            ctrl_state <= ctrl;
        end
    end

endmodule

// *** hw/lrd_pkg.sv ***
// Types of the ladder reference control block
`include "lrd_cfg.svh"
package lrd_pkg;

    // Upper ladder source, decoded
    typedef enum logic [1:0] {
        LRD_UP_SUPPLY,
        LRD_UP_EXT,
        LRD_UP_FIXED_REF,
        LRD_UP_NONE
    } lrd_upper_t;

    // Software control word
    typedef struct packed {
        logic       enable;
        logic [1:0] pin_output_enable;
        logic [1:0] positive_source_select;
        logic       negative_source_select;
        logic [4:0] level_select_field;
    } lrd_ctrl_t;

    // Analog switch controls toward the ladder
    typedef struct packed {
        logic        ladder_on;
        logic [31:0] tap_select;
        logic        upper_supply;
        logic        upper_ext;
        logic        upper_fixed_ref;
        logic        lower_ext;
        logic        lower_ground;
    } lrd_ladder_t;

    // Per-pin override controls
    typedef struct packed {
        logic [1:0] analog_connect;
        logic [1:0] digital_driver_off;
        logic [1:0] pullup_off;
        logic [1:0] input_detect_off;
    } lrd_pin_t;

endpackage

// *** test/lrd_ctrl_assertions.sv ***
// Port checker for the ladder reference control
`timescale 1ns/1ps
module lrd_ctrl_chk (
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 ctrl_write,
    input wire lrd_pkg::lrd_ctrl_t   ctrl_in,
    input wire logic                 sleep_wake,
    input wire logic [1:0]           pin_digital_in,
    input wire logic                 ladder_to_comparator,
    input wire logic                 ladder_to_adc,
    input wire lrd_pkg::lrd_ctrl_t   ctrl_state,
    input wire lrd_pkg::lrd_ladder_t ladder,
    input wire lrd_pkg::lrd_pin_t    pin_ctrl,
    input wire logic [1:0]           pin_read,
    input wire logic                 comparator_ref_sel,
    input wire logic                 adc_channel_sel,
    input wire logic                 source_reserved
);
    import lrd_pkg::*;
    // Short views of the readback fields
    wire       en  = ctrl_state.enable;
    wire [1:0] oe  = ctrl_state.pin_output_enable;
    wire [1:0] upsel = ctrl_state.positive_source_select;
    wire [4:0] lvl = ctrl_state.level_select_field;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_tap; ladder.tap_select == (en ? 32'h1 << lvl : 32'h0) && ladder.ladder_on == en;
    endproperty
    a_tap: assert property (p_tap) else $error("tap");
    property p_conn; pin_ctrl.analog_connect == oe; endproperty
    a_conn: assert property (p_conn) else $error("connect");
    property p_ovr; pin_ctrl[5:0] == {3{oe}}; endproperty
    a_ovr: assert property (p_ovr) else $error("override");
    property p_read; (pin_read & oe) == 2'h0; endproperty
    a_read: assert property (p_read) else $error("read");
    property p_wake; sleep_wake && !ctrl_write ##1 !ctrl_write |=> $stable(ctrl_state); endproperty
    a_wake: assert property (p_wake) else $error("wake");
    property p_rst; $fell(rst) |-> ctrl_state == 11'h0 && ladder == 38'h0 && pin_ctrl == 8'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_src; !$past(rst) |-> {source_reserved, ladder.upper_fixed_ref, ladder.upper_ext,
        ladder.upper_supply} == 4'h1 << upsel
        && ladder[1:0] == (ctrl_state.negative_source_select ? 2'h2 : 2'h1); endproperty
    a_src: assert property (p_src) else $error("source");
    property p_route; !$past(rst) |-> comparator_ref_sel == $past(ladder_to_comparator)
        && adc_channel_sel == $past(ladder_to_adc); endproperty
    a_route: assert property (p_route) else $error("route");
    c_wr: cover property (ctrl_write && ctrl_in.enable);
    c_rsv: cover property (source_reserved);
    c_wake: cover property (sleep_wake);
endmodule
bind lrd_ctrl lrd_ctrl_chk u_chk (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .ctrl_write           (ctrl_write),
    .ctrl_in              (ctrl_in),
    .sleep_wake           (sleep_wake),
    .pin_digital_in       (pin_digital_in),
    .ladder_to_comparator (ladder_to_comparator),
    .ladder_to_adc        (ladder_to_adc),
    .ctrl_state           (ctrl_state),
    .ladder               (ladder),
    .pin_ctrl             (pin_ctrl),
    .pin_read             (pin_read),
    .comparator_ref_sel   (comparator_ref_sel),
    .adc_channel_sel      (adc_channel_sel),
    .source_reserved      (source_reserved)
);

// *** test/lrd_ctrl_tb.sv ***
// Self-checking bench for the ladder reference control
`timescale 1ns/1ps
module lrd_ctrl_tb;
    import lrd_pkg::*;
    logic        sys_clk = 0, rst = 1, ctrl_write = 0, sleep_wake = 0;
    logic        ladder_to_comparator = 0, ladder_to_adc = 0;
    logic [1:0]  pin_digital_in = 2'h3, pin_read;
    logic        comparator_ref_sel, adc_channel_sel, source_reserved;
    lrd_ctrl_t   ctrl_in = '0, ctrl_state, c;
    lrd_ladder_t ladder, e;
    lrd_pin_t    pin_ctrl;
    int          mismatches = 0, n_checks = 0, cyc = 0;
    lrd_ctrl u_dut (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .ctrl_write           (ctrl_write),
        .ctrl_in              (ctrl_in),
        .sleep_wake           (sleep_wake),
        .pin_digital_in       (pin_digital_in),
        .ladder_to_comparator (ladder_to_comparator),
        .ladder_to_adc        (ladder_to_adc),
        .ctrl_state           (ctrl_state),
        .ladder               (ladder),
        .pin_ctrl             (pin_ctrl),
        .pin_read             (pin_read),
        .comparator_ref_sel   (comparator_ref_sel),
        .adc_channel_sel      (adc_channel_sel),
        .source_reserved      (source_reserved)
    );
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(logic [63:0] seen, logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // One control write, then wait out the output stage
    task automatic wr(lrd_ctrl_t v);
        @(negedge sys_clk);
        ctrl_write = 1'h1;
        ctrl_in = v;
        @(negedge sys_clk);
        ctrl_write = 1'h0;
        @(negedge sys_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            mismatches++;
            report_and_stop;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Every source code, both pins, level ends, then wake and reset
    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst = 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            c = '{i[0], i[2:1], i[1:0], i[2], 5'(i * 9)};
            e = '{i[0], i[0] ? 32'h1 << 5'(i * 9) : 32'h0, i[1:0] == 2'h0,
                  i[1:0] == 2'h1, i[1:0] == 2'h2, i[2], !i[2]};
            ladder_to_comparator = i[0];
            ladder_to_adc = i[1];
            sleep_wake = i[2];
            pin_digital_in = 2'(~i);
            wr(c);
            chk(ctrl_state, c);
            chk(ladder, e);
            chk(pin_ctrl, {4{i[2:1]}});
            chk(pin_read, 2'(~i) & ~i[2:1]);
            chk(source_reserved, i[1:0] == 2'h3);
            chk({comparator_ref_sel, adc_channel_sel}, {i[0], i[1]});
        end
        sleep_wake = 1'h1;
        repeat (4) @(negedge sys_clk);
        chk(ctrl_state, c);
        rst = 1'h1;
        @(negedge sys_clk);
        rst = 1'h0;
        chk({ctrl_state, ladder, pin_ctrl}, 57'h0);
        repeat (2) @(negedge sys_clk);
        chk(ctrl_state, 11'h0);
        report_and_stop;
    end
endmodule
